/* ppmt_pkg.sv */
// Package: register map, field layout, codes and carriers of the parallel port mode block
// Function
// (R1) Read-only busy flag is 1 during a port transfer; useless while processor stall is on.
// (R2) Busy flag only has meaning in the master modes.
// (R3) Interrupt mode 11 interrupts on fourth buffer access or address bits equal 11.
// (R4) Interrupt mode 10 raises no interrupt and stalls the processor until the access ends.
// (R5) Interrupt mode 01 interrupts after each read or write cycle; 00 never interrupts.
// (R6) Increment mode 11 advances the slave buffer pointers, legacy slave mode only.
// (R7) Increment mode 10 decrements, 01 increments, 00 keeps the port address per cycle.
// (R8) Wide data select 1: 16-bit data register, two 8-bit bus transfers per access.
// (R9) Wide data select 0: 8-bit data register, one 8-bit bus transfer per access.
// (R10) Port mode 11 is master mode 1: direction line plus enable strobe.
// (R11) Port mode 10 is master mode 2: separate read and write strobes.
// (R12) Port mode 01 is enhanced slave: host drives strobes, select and two address bits.
// (R13) Port mode 00 is legacy slave: host drives strobes and select, no address bits.
// (R14) Setup wait codes 00 to 11 give 1 to 4 cycles before the strobe.
// (R15) Strobe wait adds 0 to 15 cycles; 0000 makes the whole operation one cycle.
// (R16) Hold wait codes 00 to 11 hold data 1 to 4 cycles after the strobe.
// (R17) Setup and hold waits are ignored while strobe wait is 0000.
// (R18) Busy rises when a master transfer starts and falls after its last hold cycle.
// (R19) All wait states count cycles of the single block clock.
package ppmt_pkg;

  localparam int unsigned AXI_AW = 8;
  localparam int unsigned BUF_N  = 4;
  localparam int unsigned STAT_W = 2;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFF_MODE   = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_ADDR   = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_DATA   = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_STAT   = 8'h0c;
  localparam logic [AXI_AW-1:0] OFF_MASK   = 8'h10;
  localparam logic [AXI_AW-1:0] OFF_INBUF  = 8'h14;
  localparam logic [AXI_AW-1:0] OFF_OUTBUF = 8'h18;

  // Reset values
  localparam logic [15:0]       MODE_RST = 16'h0000;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

  // Status bit positions
  localparam int unsigned STAT_CYC = 0;
  localparam int unsigned STAT_BUF = 1;

  // Interrupt request modes
  localparam logic [1:0] IRQ_NONE  = 2'b00;
  localparam logic [1:0] IRQ_CYCLE = 2'b01;
  localparam logic [1:0] IRQ_STALL = 2'b10;
  localparam logic [1:0] IRQ_BUF3  = 2'b11;

  // Address step modes
  localparam logic [1:0] INC_NONE = 2'b00;
  localparam logic [1:0] INC_UP   = 2'b01;
  localparam logic [1:0] INC_DOWN = 2'b10;
  localparam logic [1:0] INC_BUF  = 2'b11;

  // Port modes
  localparam logic [1:0] PM_LEGACY = 2'b00;
  localparam logic [1:0] PM_ENH    = 2'b01;
  localparam logic [1:0] PM_MST2   = 2'b10;
  localparam logic [1:0] PM_MST1   = 2'b11;

  localparam logic [1:0] LAST_BUF    = 2'b11;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Port mode register layout, bit 15 down to bit 0
  typedef struct packed {
    logic       busy;
    logic [1:0] interrupt_request_mode;
    logic [1:0] address_step_mode;
    logic       wide_data_select;
    logic [1:0] port_mode;
    logic [1:0] setup_wait;
    logic [3:0] strobe_wait;
    logic [1:0] hold_wait;
  } ppmt_mode_s;

  // Sampled host-side pins
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [1:0] adr;
    logic [7:0] data;
  } ppmt_host_s;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } ppmt_state_e;

endpackage

/* ppmt_top.sv */
// Module: parallel port mode and wait-state engine with AXI4-Lite registers
module ppmt_top import ppmt_pkg::*; #(
  parameter int unsigned ADDR_W = 11
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq,
  output logic                   stall,
  output logic                   chip_select_one_drive,
  output logic                   chip_select_one_en,
  input  wire logic              chip_select_one_sense,
  output logic                   read_strobe_drive,
  output logic                   read_strobe_en,
  input  wire logic              read_strobe_sense,
  output logic                   write_strobe_drive,
  output logic                   write_strobe_en,
  input  wire logic              write_strobe_sense,
  output logic                   enable_strobe,
  output logic                   byte_enable,
  output logic [ADDR_W-1:0]      port_address_lines_drive,
  output logic                   port_address_lines_en,
  input  wire logic [1:0]        port_address_lines_sense,
  output logic [7:0]             port_data_lines_drive,
  output logic                   port_data_lines_en,
  input  wire logic [7:0]        port_data_lines_sense
);

  if (ADDR_W < 2 || ADDR_W > 16) begin : g_bad_width
    $error("ADDR_W must lie in 2 to 16");
  end

  // Byte-lane merge of a register word with write data
  function automatic logic [31:0] ppmt_merge(input logic [31:0] old, input logic [31:0] nv,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nv[8*i +: 8];
      end
    end
    return r;
  endfunction

  ppmt_mode_s        mode_q;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0]       tx_q;
  logic [15:0]       rx_q;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;
  logic [STAT_W-1:0] mask_q;
  logic [7:0]        in_buf [BUF_N];
  logic [7:0]        out_buf [BUF_N];
  logic [1:0]        ptr_q;
  ppmt_host_s        h1_q;
  ppmt_host_s        h2_q;
  ppmt_host_s        h3_q;
  ppmt_state_e       st_q;
  ppmt_state_e       st_d;
  ppmt_state_e       first_st;
  logic [3:0]        cnt_q;
  logic [3:0]        cnt_d;
  logic [3:0]        first_cnt;
  logic              dir_q;
  logic              dir_d;
  logic              sel_q;
  logic              sel_d;
  logic              byte_done;
  logic              aw_got_q;
  logic              w_got_q;
  logic              ar_got_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [AXI_AW-1:0] araddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_pend_q;
  logic              rd_pend_q;
  logic [31:0]       rmux;

  // Decode of mode, bus and host activity
  wire master     = mode_q.port_mode[1];
  wire legacy     = mode_q.port_mode == PM_LEGACY;
  wire busy_now   = st_q != ST_IDLE;
  wire wr_data    = awaddr_q == OFF_DATA;
  wire wr_lock    = wr_data | (awaddr_q == OFF_MODE) | (awaddr_q == OFF_ADDR);
  wire wr_known   = wr_lock | (awaddr_q == OFF_STAT) | (awaddr_q == OFF_MASK)
                  | (awaddr_q == OFF_INBUF) | (awaddr_q == OFF_OUTBUF);
  wire rd_data    = araddr_q == OFF_DATA;
  wire do_wr      = aw_got_q & w_got_q & ~wr_pend_q & ~s_axi_bvalid & ~(wr_lock & busy_now);
  wire do_rd      = ar_got_q & ~rd_pend_q & ~s_axi_rvalid & ~(rd_data & busy_now);
  wire wr_release = wr_pend_q & ~s_axi_bvalid & ~stall;    // see R4
  wire rd_release = rd_pend_q & ~s_axi_rvalid & ~stall;    // see R4
  wire go_wr      = do_wr & wr_data & master;
  wire go_rd      = do_rd & rd_data & master;
  wire [31:0] wd_mode = ppmt_merge({16'h0000, mode_q}, wdata_q, wstrb_q);
  wire [31:0] wd_addr = ppmt_merge({{(32-ADDR_W){1'b0}}, addr_q}, wdata_q, wstrb_q);
  wire [31:0] wd_mask = ppmt_merge({{(32-STAT_W){1'b0}}, mask_q}, wdata_q, wstrb_q);
  wire [31:0] wd_out  = ppmt_merge({out_buf[3], out_buf[2], out_buf[1], out_buf[0]},
                                   wdata_q, wstrb_q);
  wire [31:0] wd_tx   = ppmt_merge({16'h0000, tx_q}, wdata_q, wstrb_q);
  wire h_rd_now   = h2_q.cs & h2_q.rd;
  wire h_rd_end   = ~master & h3_q.cs & h3_q.rd & ~h_rd_now;
  wire h_wr_end   = ~master & h3_q.cs & h3_q.wr & ~(h2_q.cs & h2_q.wr);
  wire h_end      = h_rd_end | h_wr_end;
  wire [1:0] sidx     = legacy ? ptr_q : h3_q.adr;                 // see R12, R13
  wire [1:0] sidx_now = legacy ? ptr_q : h2_q.adr;
  wire ev_cyc = (mode_q.interrupt_request_mode == IRQ_CYCLE) & (byte_done | h_end);  // see R5
  wire ev_buf = (mode_q.interrupt_request_mode == IRQ_BUF3) & h_end & (sidx == LAST_BUF)
              & (~legacy | (mode_q.address_step_mode == INC_BUF));                  // see R3
  wire stat_clr = rd_release & (araddr_q == OFF_STAT);

  // Read data selection
  always_comb begin
    case (araddr_q)
      OFF_MODE:   rmux = {16'h0000, busy_now & master, mode_q[14:0]};   // see R1, R2
      OFF_ADDR:   rmux = {{(32-ADDR_W){1'b0}}, addr_q};
      OFF_DATA:   rmux = mode_q.wide_data_select ? {16'h0000, rx_q} : {24'h000000, rx_q[7:0]};
      OFF_STAT:   rmux = {{(32-STAT_W){1'b0}}, stat_q};
      OFF_MASK:   rmux = {{(32-STAT_W){1'b0}}, mask_q};
      OFF_INBUF:  rmux = {in_buf[3], in_buf[2], in_buf[1], in_buf[0]};
      OFF_OUTBUF: rmux = {out_buf[3], out_buf[2], out_buf[1], out_buf[0]};
      default:    rmux = 32'h00000000;
    endcase
  end

  // First phase of a byte: setup, or straight to the strobe when strobe wait is zero
  assign first_st  = (mode_q.strobe_wait == 4'h0) ? ST_STROBE : ST_SETUP;          // see R17
  assign first_cnt = (mode_q.strobe_wait == 4'h0) ? 4'h0 : {2'b00, mode_q.setup_wait};

  // Transfer sequencer; counts run on every rising clock edge
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    dir_d     = dir_q;
    sel_d     = sel_q;
    byte_done = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (go_wr | go_rd) begin                                   // see R18
          st_d  = first_st;
          cnt_d = first_cnt;
          dir_d = go_rd;
          sel_d = 1'b0;
        end
      end
      ST_SETUP: begin
        if (cnt_q == 4'h0) begin                                   // see R14
          st_d  = ST_STROBE;
          cnt_d = mode_q.strobe_wait;
        end else begin
          cnt_d = cnt_q - 4'h1;                                    // see R19
        end
      end
      ST_STROBE: begin
        if (cnt_q != 4'h0) begin                                   // see R15
          cnt_d = cnt_q - 4'h1;
        end else if (mode_q.strobe_wait == 4'h0) begin
          byte_done = 1'b1;                                        // see R15, R17
        end else begin
          st_d  = ST_HOLD;
          cnt_d = {2'b00, mode_q.hold_wait};
        end
      end
      ST_HOLD: begin
        if (cnt_q == 4'h0) begin                                   // see R16
          byte_done = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (byte_done) begin
      if (mode_q.wide_data_select & ~sel_q) begin                  // see R8
        sel_d = 1'b1;
        st_d  = first_st;
        cnt_d = first_cnt;
      end else begin
        st_d  = ST_IDLE;                                           // see R9, R18
      end
    end
  end

  // Sticky status, set wins over the read clear
  assign stat_d = (stat_q & ~{STAT_W{stat_clr}}) | {ev_buf, ev_cyc};

  // Host pin synchroniser, third stage for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h1_q <= '0;
      h2_q <= '0;
      h3_q <= '0;
    end else begin
      h1_q <= '{chip_select_one_sense, read_strobe_sense, write_strobe_sense,
                port_address_lines_sense, port_data_lines_sense};
      h2_q <= h1_q;
      h3_q <= h2_q;
    end
  end

  // Sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= ST_IDLE;
      cnt_q <= 4'h0;
      dir_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      sel_q <= sel_d;
    end
  end

  // Master pin outputs, registered from the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_select_one_drive <= 1'b0;
      read_strobe_drive     <= 1'b0;
      write_strobe_drive    <= 1'b0;
      enable_strobe         <= 1'b0;
      byte_enable           <= 1'b0;
      stall                 <= 1'b0;
    end else begin
      chip_select_one_drive <= st_d != ST_IDLE;
      read_strobe_drive     <= (mode_q.port_mode == PM_MST1) ? (st_d != ST_IDLE) & dir_d  // see R10
                                                             : (st_d == ST_STROBE) & dir_d; // see R11
      write_strobe_drive    <= (mode_q.port_mode == PM_MST2) & (st_d == ST_STROBE) & ~dir_d;
      enable_strobe         <= (mode_q.port_mode == PM_MST1) & (st_d == ST_STROBE);  // see R10
      byte_enable           <= st_d != ST_IDLE;
      stall <= (mode_q.interrupt_request_mode == IRQ_STALL) & (st_d != ST_IDLE);     // see R4
    end
  end

  // Pin enables and data lines; select, strobe and address pins are inputs in the slave modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_select_one_en    <= 1'b0;
      read_strobe_en        <= 1'b0;
      write_strobe_en       <= 1'b0;
      port_address_lines_en <= 1'b0;
      port_data_lines_en    <= 1'b0;
      port_data_lines_drive <= 8'h00;
    end else begin
      chip_select_one_en    <= master;                             // see R12, R13
      read_strobe_en        <= master;
      write_strobe_en       <= master;
      port_address_lines_en <= master;
      port_data_lines_en    <= master ? (st_d != ST_IDLE) & ~dir_d : h_rd_now;
      port_data_lines_drive <= master ? (sel_d ? tx_q[15:8] : tx_q[7:0]) : out_buf[sidx_now];
    end
  end

  // Port address, read data capture, stepping after each byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= '0;
      rx_q   <= 16'h0000;
    end else begin
      if (byte_done & dir_q) begin
        rx_q[8*sel_q +: 8] <= h2_q.data;
      end
      if (byte_done && mode_q.address_step_mode == INC_UP) begin   // see R7
        addr_q <= addr_q + 1'b1;
      end else if (byte_done && mode_q.address_step_mode == INC_DOWN) begin
        addr_q <= addr_q - 1'b1;
      end else if (do_wr && awaddr_q == OFF_ADDR) begin
        addr_q <= wd_addr[ADDR_W-1:0];
      end
    end
  end
  assign port_address_lines_drive = addr_q;

  // Slave buffers and legacy pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= 2'b00;
      for (int i = 0; i < BUF_N; i++) begin
        in_buf[i]  <= 8'h00;
        out_buf[i] <= 8'h00;
      end
    end else begin
      if (h_wr_end) begin
        in_buf[sidx] <= h3_q.data;
      end
      if (h_end & legacy & (mode_q.address_step_mode == INC_BUF)) begin  // see R6
        ptr_q <= ptr_q + 2'b01;
      end
      if (do_wr && awaddr_q == OFF_OUTBUF) begin
        for (int i = 0; i < BUF_N; i++) begin
          out_buf[i] <= wd_out[8*i +: 8];
        end
      end
    end
  end

  // Software registers, status and interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_RST;
      mask_q <= MASK_RST;
      tx_q   <= 16'h0000;
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq    <= |(stat_d & mask_q);
      if (do_wr && awaddr_q == OFF_MODE) begin
        mode_q <= {1'b0, wd_mode[14:0]};
      end
      if (do_wr && awaddr_q == OFF_MASK) begin
        mask_q <= wd_mask[STAT_W-1:0];
      end
      if (do_wr & wr_data) begin
        tx_q <= wd_tx[15:0];
      end
    end
  end

  // AXI write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      wr_pend_q     <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_got_q      <= (aw_got_q | (s_axi_awvalid & s_axi_awready)) & ~do_wr;
      w_got_q       <= (w_got_q | (s_axi_wvalid & s_axi_wready)) & ~do_wr;
      s_axi_awready <= ~(aw_got_q | (s_axi_awvalid & s_axi_awready)) | do_wr;
      s_axi_wready  <= ~(w_got_q | (s_axi_wvalid & s_axi_wready)) | do_wr;
      if (do_wr) begin
        wr_pend_q   <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (wr_release) begin
        wr_pend_q <= 1'b0;
      end
      if (wr_release) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel; a read of the data register in a master mode also starts a port read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_got_q      <= 1'b0;
      s_axi_arready <= 1'b0;
      araddr_q      <= '0;
      rd_pend_q     <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        araddr_q <= s_axi_araddr;
      end
      ar_got_q      <= (ar_got_q | (s_axi_arvalid & s_axi_arready)) & ~do_rd;
      s_axi_arready <= ~(ar_got_q | (s_axi_arvalid & s_axi_arready)) | do_rd;
      if (do_rd) begin
        rd_pend_q <= 1'b1;
      end else if (rd_release) begin
        rd_pend_q <= 1'b0;
      end
      if (rd_release) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux;
        s_axi_rresp  <= (araddr_q <= OFF_OUTBUF && araddr_q[1:0] == 2'b00) ? RESP_OKAY
                                                                          : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks: phase lengths measured by a helper counter
  logic [3:0] run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || st_d != st_q || byte_done) begin
      run_q <= 4'h0;
    end else begin
      run_q <= run_q + 4'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_busy_start: assert property ($rose(busy_now) |-> $past(go_wr | go_rd)) // see R18
    else $error("busy rose without a start");
  chk_busy_slave: assert property (~master |-> ~busy_now // see R1, R2
      && (araddr_q != OFF_MODE || rmux[15] == 1'b0)) else $error("busy seen in a slave mode");
  chk_stall_resp: assert property ($rose(s_axi_bvalid) |-> !$past(stall)) // see R4
    else $error("write answered during stall");
  chk_setup_len: assert property (st_q == ST_SETUP && st_d != ST_SETUP |-> // see R14
      run_q == {2'b00, mode_q.setup_wait}) else $error("setup phase length wrong");
  chk_strobe_len: assert property (st_q == ST_STROBE && (st_d != ST_STROBE || byte_done) |-> // see R15
      run_q == mode_q.strobe_wait) else $error("strobe phase length wrong");
  chk_hold_len: assert property (st_q == ST_HOLD && byte_done |-> // see R16
      run_q == {2'b00, mode_q.hold_wait}) else $error("hold phase length wrong");
  chk_no_setup: assert property (mode_q.strobe_wait == 4'h0 |-> st_q != ST_SETUP // see R17
      && st_q != ST_HOLD) else $error("setup or hold used with zero strobe wait");
  chk_addr_step: assert property (byte_done && mode_q.address_step_mode == INC_UP |=> // see R7
      addr_q == $past(addr_q) + 1'b1) else $error("address did not step up");
  chk_wide_bytes: assert property (byte_done && st_d == ST_IDLE |-> // see R8, R9
      sel_q == mode_q.wide_data_select) else $error("wrong byte count per access");
  chk_legacy_ptr: assert property (h_end && legacy && mode_q.address_step_mode == INC_BUF // see R6
      |=> ptr_q == $past(ptr_q) + 2'b01) else $error("legacy pointer did not advance");
  chk_cycle_irq: assert property (byte_done && mode_q.interrupt_request_mode == IRQ_CYCLE // see R5
      |=> stat_q[STAT_CYC]) else $error("cycle event not flagged");
  chk_buf3_irq: assert property (ev_buf |-> (h3_q.adr == LAST_BUF || legacy) // see R3
      ##1 stat_q[STAT_BUF]) else $error("buffer event not flagged");
  chk_mst_strobe: assert property (mode_q.port_mode == PM_MST2 |-> ~enable_strobe) // see R11
    else $error("enable strobe in master mode 2");

  cov_wide_write: cover property (go_wr && mode_q.wide_data_select ##[1:60] byte_done && sel_q);
  cov_stall_read: cover property (go_rd && mode_q.interrupt_request_mode == IRQ_STALL
      ##[1:60] $rose(s_axi_rvalid));
  cov_buf3_event: cover property (ev_buf);

endmodule

/* ppmt_periph.sv */
// External peripheral model answering master-mode reads
module ppmt_periph (
  input  wire logic       aclk,
  input  wire logic       sel,
  input  wire logic       rd,
  input  wire logic [7:0] adr,
  output logic [7:0]      dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q = 8'h00;
  logic [1:0] hold_q = 2'h0;
  // Keep the last byte for a short hold after release
  always_ff @(posedge aclk) begin
    if (sel && rd) begin
      last_q <= adr ^ 8'ha5;
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  // Read data follows the address; after release the last byte stays for three cycles, then the bus shows stale garbage
  assign dq = (sel && rd) ? (adr ^ 8'ha5) : ((hold_q != 2'h0) ? last_q : ~last_q);
endmodule

/* tb_parallel_port_mode_timing.sv */
// Self-checking bench for the parallel port mode and wait-state engine
module tb_parallel_port_mode_timing import ppmt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq, stall, chip_select_one_drive, chip_select_one_en;
  logic read_strobe_drive, read_strobe_en, write_strobe_drive, write_strobe_en;
  logic port_data_lines_en, cs_w, rd_w, stall_hit = 0, enable_strobe, byte_enable, pa_en;
  logic h_cs = 0, h_wr = 0;
  logic [1:0] h_adr = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, port_data_lines_drive, dq, pd_w, h_d = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [10:0] port_address_lines_drive;
  int error_cnt = 0, checks = 0, cs_cnt = 0, en_cnt = 0, be_cnt = 0, ws_cnt = 0;
  // Wire levels: the host drives select, write strobe and data in the slave modes
  assign cs_w = chip_select_one_en ? chip_select_one_drive : h_cs;
  assign rd_w = read_strobe_en & read_strobe_drive;
  assign pd_w = port_data_lines_en ? port_data_lines_drive : (h_wr ? h_d : dq);
  ppmt_top ppmt_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .stall, .chip_select_one_drive, .chip_select_one_en,
    .chip_select_one_sense(cs_w), .read_strobe_drive, .read_strobe_en, .read_strobe_sense(rd_w),
    .write_strobe_drive, .write_strobe_en,
    .write_strobe_sense(write_strobe_en ? write_strobe_drive : h_wr), .enable_strobe,
    .byte_enable, .port_address_lines_drive, .port_address_lines_en(pa_en),
    .port_address_lines_sense(h_adr), .port_data_lines_drive, .port_data_lines_en,
    .port_data_lines_sense(pd_w));
  ppmt_periph ppmt_periph_i (.aclk, .sel(cs_w), .rd(rd_w),
    .adr(port_address_lines_drive[7:0]), .dq);
  // Clock and select-width monitor
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (chip_select_one_drive) cs_cnt++;
    if (enable_strobe) en_cnt++;
    if (byte_enable) be_cnt++;
    if (write_strobe_drive) ws_cnt++;
    if (stall) stall_hit = 1;
  end
  task end_sim;
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One AXI4-Lite access; result lands in q and r
  task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) break;
    end
    q = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 300) begin
      error_cnt++;
      end_sim;
    end
  endtask
  // Wait until the port transfer has released chip select
  task settle;
    for (int n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (!chip_select_one_drive) return;
    end
    error_cnt++;
    end_sim;
  endtask
  task t_reset;
    bus(0, OFF_MODE, 0);
    chk(q, {16'h0, MODE_RST});
    bus(0, 8'h1c, 0);
    chk(r, RESP_SLVERR);
  endtask
  task t_narrow_write;
    bus(1, OFF_MASK, 32'h3);
    bus(1, OFF_ADDR, 32'h10);
    bus(1, OFF_MODE, 32'haa3c);
    bus(0, OFF_MODE, 0);
    chk(q, 32'h2a3c);
    cs_cnt = 0;
    ws_cnt = 0;
    bus(1, OFF_DATA, 32'h5a);
    bus(0, OFF_MODE, 0);
    chk(q[15], 1);
    settle;
    chk(cs_cnt, 18);
    chk(ws_cnt, 16);
    bus(0, OFF_ADDR, 0);
    chk(q, 32'h11);
    chk(irq, 1);
    bus(0, OFF_STAT, 0);
    chk(q, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
  endtask
  task t_wide_fast;
    bus(1, OFF_MODE, 32'h16c3);
    bus(1, OFF_ADDR, 32'h20);
    cs_cnt = 0;
    bus(1, OFF_DATA, 32'h1234);
    settle;
    chk(cs_cnt, 2);
    bus(0, OFF_ADDR, 0);
    chk(q, 32'h1e);
    bus(0, OFF_STAT, 0);
    chk(q, 32'h0);
  endtask
  task t_stall_read;
    bus(1, OFF_MODE, 32'h4705);
    bus(1, OFF_ADDR, 32'h33);
    cs_cnt = 0;
    en_cnt = 0;
    be_cnt = 0;
    bus(0, OFF_DATA, 0);
    chk(q, 32'h9696);
    settle;
    chk(cs_cnt, 10);
    chk(en_cnt, 4);
    chk(be_cnt, 10);
    chk(stall_hit, 1);
    chk(irq, 0);
  endtask
  // Enhanced slave: host writes buffer 3, which raises the buffer event
  task t_host_write;
    bus(1, OFF_MODE, 32'h6100);
    chk(r, RESP_OKAY);
    chk(pa_en, 0);
    {h_cs, h_wr, h_adr, h_d} <= {4'hf, 8'hc3};
    repeat (4) @(posedge aclk);
    {h_cs, h_wr} <= 2'h0;
    repeat (4) @(posedge aclk);
    bus(0, OFF_INBUF, 0);
    chk(q, 32'hc3000000);
    chk(irq, 1);
    bus(0, OFF_STAT, 0);
    chk(q, 32'h2);
  endtask
  // Reset for ten cycles, then run the scenarios
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_narrow_write;
    t_wide_fast;
    t_stall_read;
    t_host_write;
    end_sim;
  end
endmodule
